// File: logic/dcf_fifo.sv
// 18-bit fifo with standard and fall-through timing and derived flags
// assumes pin clocks well below clk/2; registers reached over avalon-mm
//
// Overview of operation
// RQ1: timing mode is caught from three config pins while device reset is held
// RQ2: standard mode: a written word reaches the output only on a read
// RQ3: fall-through: first word appears after three read clock transitions
// RQ4: write enable low at write clock rise stores the word unless full
// RQ5: standard mode: empty flag goes high after the first write
// RQ6: standard mode: almost-empty high when count exceeds empty offset
// RQ7: standard mode: half-full low when count exceeds half the depth
// RQ8: standard mode: almost-full low when count reaches depth minus m
// RQ9: full offset defaults to 31, 63 or 127 by depth
// RQ10: standard mode: full flag low at depth words; writes then ignored
// RQ11: standard mode: reads from full release full, almost-full, half-full
// RQ12: empty offset defaults to 31, 63 or 127 by depth
// RQ13: standard mode: empty flag low after last read; reads then ignored
// RQ14: fall-through: output-ready low once the first word is presented
// RQ15: fall-through: almost-empty high from n plus two words
// RQ16: fall-through: half-full low from half depth plus two words
// RQ17: fall-through: almost-full low from depth plus one minus m
// RQ18: fall-through: input-ready high at depth plus one words, blocking writes
// RQ19: fall-through: reads from full release input-ready and partial flags
// RQ20: fall-through default almost-empty low within 32, 64 or 128 words
// RQ21: fall-through: output-ready high after last read; reads then ignored
// RQ22: load and write enable low write offsets, alternating empty then full
// RQ23: depth is a parameter from 256 to 4096; thresholds follow it
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic device_reset_pin_n,
  input wire logic first_load_pin,
  input wire logic read_expand_in,
  input wire logic write_expand_in,
  input wire logic offset_load_n,
  input wire logic wr_clk_pin,
  input wire logic wr_en_n,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic rd_clk_pin,
  input wire logic rd_en_n,
  output logic [DATA_W-1:0] data_out,
  output logic full_flag_n,
  output logic input_ready_n,
  output logic almost_full_flag_n,
  output logic half_full_flag_n,
  output logic almost_empty_flag_n,
  output logic empty_flag_n,
  output logic output_ready_n,
  output logic fall_through_mode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(DEPTH / 2);
  localparam logic [OFS_W-1:0] OFS_DEF = dcf_ofs_default(DEPTH);

  // only power-of-two depths in the documented range are served
  if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("dcf_fifo: DEPTH must be 256, 512, 1024, 2048 or 4096"); // [RQ23]
  end

  // pins pass the synchroniser bank; data rides with its clock
  localparam int unsigned SW = DATA_W + 9;
  logic [SW-1:0] s_lvl;
  logic [SW-1:0] s_rise;
  logic [SW-1:0] s_fall;

  dcf_pin_sync #(
    .W(SW)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({data_in, device_reset_pin_n, first_load_pin, read_expand_in,
             write_expand_in, offset_load_n, wr_clk_pin, wr_en_n, rd_clk_pin, rd_en_n}),
    .level_out(s_lvl),
    .rise_out(s_rise),
    .fall_out(s_fall)
  );

  logic [DATA_W-1:0] din_s;
  logic dev_rst;
  logic cfg_fl;
  logic cfg_rxi;
  logic cfg_wxi;
  logic ld_n_s;
  logic wr_edge;
  logic wen_n_s;
  logic rd_edge;
  logic rd_trans;
  logic ren_n_s;

  assign din_s = s_lvl[SW-1 -: DATA_W];
  assign dev_rst = ~s_lvl[8];
  assign cfg_fl = s_lvl[7];
  assign cfg_rxi = s_lvl[6];
  assign cfg_wxi = s_lvl[5];
  assign ld_n_s = s_lvl[4];
  assign wr_edge = s_rise[3];
  assign wen_n_s = s_lvl[2];
  assign rd_edge = s_rise[1];
  assign rd_trans = s_rise[1] | s_fall[1];
  assign ren_n_s = s_lvl[0];

  // storage and pointers
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CNT_W-1:0] mem_cnt_r;
  logic out_valid_r;
  logic [1:0] ft_cnt_r;
  logic [OFS_W-1:0] empty_ofs_r;
  logic [OFS_W-1:0] full_ofs_r;
  logic ofs_sel_r;
  logic mode_ft_r;
  logic [DATA_W-1:0] dout_r;

  logic push;
  logic pop;
  logic ofs_load;
  logic std_read;
  logic ft_read;
  logic ft_fall;
  logic [CNT_W-1:0] total;

  // writes stop once memory holds depth words; in fall-through the output
  // register adds the extra word, so depth plus one blocks too
  assign ofs_load = wr_edge & ~wen_n_s & ~ld_n_s & ~dev_rst; // [RQ22]
  assign push = wr_edge & ~wen_n_s & ld_n_s & ~dev_rst
                & (mem_cnt_r != DEPTH_C); // [RQ4] [RQ10] [RQ18]
  // reads with nothing stored are dropped
  assign std_read = ~mode_ft_r & rd_edge & ~ren_n_s & ld_n_s & (mem_cnt_r != '0); // [RQ2] [RQ13]
  assign ft_read = mode_ft_r & rd_edge & ~ren_n_s & ld_n_s & out_valid_r; // [RQ21]
  assign ft_fall = mode_ft_r & ~out_valid_r & (mem_cnt_r != '0) & rd_trans
                   & (ft_cnt_r == FT_TRANSITIONS - 2'h1); // [RQ3]
  assign pop = std_read | (ft_read & (mem_cnt_r != '0)) | ft_fall;
  assign total = mem_cnt_r + CNT_W'(mode_ft_r & out_valid_r);

  // mode capture while the device reset pin is held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ft_r <= 1'b0;
    end else if (dev_rst) begin
      mode_ft_r <= ({cfg_fl, cfg_rxi, cfg_wxi} == FT_MODE_PINS); // [RQ1]
    end
  end

  // memory array, no reset needed: pointers guard the contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= din_s; // [RQ4]
    end
  end

  // write pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
    end else if (dev_rst) begin
      wptr_r <= '0;
    end else if (push) begin
      wptr_r <= wptr_r + AW'(1);
    end
  end

  // read pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr_r <= '0;
    end else if (dev_rst) begin
      rptr_r <= '0;
    end else if (pop) begin
      rptr_r <= rptr_r + AW'(1);
    end
  end

  // stored word count; push and pop may land in one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_cnt_r <= '0;
    end else if (dev_rst) begin
      mem_cnt_r <= '0;
    end else if (push && !pop) begin
      mem_cnt_r <= mem_cnt_r + CNT_W'(1);
    end else if (pop && !push) begin
      mem_cnt_r <= mem_cnt_r - CNT_W'(1);
    end
  end

  // fall-through transition counter: runs only while a word waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ft_cnt_r <= '0;
    end else if (dev_rst || out_valid_r || mem_cnt_r == '0 || ft_fall) begin
      ft_cnt_r <= '0;
    end else if (mode_ft_r && rd_trans) begin
      ft_cnt_r <= ft_cnt_r + 2'h1; // [RQ3]
    end
  end

  // output register holds a word in fall-through mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
    end else if (dev_rst) begin
      out_valid_r <= 1'b0;
    end else if (ft_fall) begin
      out_valid_r <= 1'b1; // [RQ14]
    end else if (ft_read && mem_cnt_r == '0) begin
      out_valid_r <= 1'b0; // [RQ21]
    end
  end

  // output data bus; standard mode only moves it on a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= '0;
    end else if (dev_rst) begin
      dout_r <= '0;
    end else if (pop) begin
      dout_r <= mem[rptr_r]; // [RQ2] [RQ3]
    end
  end
  assign data_out = dout_r;

  // offsets: load pin alternates empty then full; bus may also write them
  logic bus_ofs_wr;
  assign bus_ofs_wr = avs_write & ~avs_waitrequest & (avs_address == ADDR_OFFSETS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_ofs_r <= OFS_DEF;
      full_ofs_r <= OFS_DEF;
      ofs_sel_r <= 1'b0;
    end else if (dev_rst) begin
      empty_ofs_r <= OFS_DEF; // [RQ12] [RQ20]
      full_ofs_r <= OFS_DEF; // [RQ9]
      ofs_sel_r <= 1'b0;
    end else if (ofs_load) begin
      ofs_sel_r <= ~ofs_sel_r; // [RQ22]
      if (!ofs_sel_r) begin
        empty_ofs_r <= din_s[OFS_W-1:0];
      end else begin
        full_ofs_r <= din_s[OFS_W-1:0];
      end
    end else if (bus_ofs_wr) begin
      // a field moves only when both of its byte lanes are enabled
      if (avs_byteenable[1:0] == 2'h3) begin
        empty_ofs_r <= avs_writedata[OF_EMPTY_LSB +: OFS_W];
      end
      if (avs_byteenable[3:2] == 2'h3) begin
        full_ofs_r <= avs_writedata[OF_FULL_LSB +: OFS_W];
      end
    end
  end

  // thresholds in 14 bits so a large m never wraps below zero
  logic [CNT_W:0] tot_w;
  logic [CNT_W:0] ae_lim;
  logic [CNT_W:0] hf_lim;
  logic [CNT_W:0] af_sum;
  logic [CNT_W:0] af_lim;
  logic [CNT_W:0] full_lim;
  logic avail;
  logic is_full;

  assign tot_w = {1'b0, total};
  assign ae_lim = (CNT_W+1)'(empty_ofs_r) + (CNT_W+1)'(1) + (CNT_W+1)'(mode_ft_r); // [RQ6] [RQ15]
  assign hf_lim = {1'b0, HALF_C} + (CNT_W+1)'(1) + (CNT_W+1)'(mode_ft_r); // [RQ7] [RQ16]
  assign af_sum = tot_w + (CNT_W+1)'(full_ofs_r);
  assign af_lim = {1'b0, DEPTH_C} + (CNT_W+1)'(mode_ft_r); // [RQ8] [RQ17]
  assign full_lim = {1'b0, DEPTH_C} + (CNT_W+1)'(mode_ft_r); // [RQ10] [RQ18] [RQ23]
  assign avail = mode_ft_r ? out_valid_r : (mem_cnt_r != '0);
  assign is_full = (tot_w == full_lim);

  // flags follow the count one clk later; both encodings are always driven
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_flag_n <= 1'b1;
      input_ready_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
      half_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      empty_flag_n <= 1'b0;
      output_ready_n <= 1'b1;
    end else begin
      full_flag_n <= ~is_full; // [RQ10] [RQ11]
      input_ready_n <= is_full; // [RQ18] [RQ19]
      almost_full_flag_n <= ~(af_sum >= af_lim); // [RQ8] [RQ11] [RQ17] [RQ19]
      half_full_flag_n <= ~(tot_w >= hf_lim); // [RQ7] [RQ16]
      almost_empty_flag_n <= (tot_w >= ae_lim); // [RQ6] [RQ15] [RQ20]
      empty_flag_n <= avail; // [RQ5] [RQ13]
      output_ready_n <= ~avail; // [RQ14] [RQ21]
    end
  end

  // mode pin to the outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_through_mode <= 1'b0;
    end else begin
      fall_through_mode <= mode_ft_r;
    end
  end

  // avalon slave: one wait cycle, answer on the second edge of a request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // read data is captured in the wait cycle so it stands at the answer edge
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_COUNT_LSB +: CNT_W] = total;
    status_word[ST_MODE_BIT] = mode_ft_r;
    status_word[ST_EMPTY_BIT] = ~avail;
    status_word[ST_AE_BIT] = ~(tot_w >= ae_lim);
    status_word[ST_HF_BIT] = (tot_w >= hf_lim);
    status_word[ST_AF_BIT] = (af_sum >= af_lim);
    status_word[ST_FULL_BIT] = is_full;
    status_word[ST_RESET_BIT] = dev_rst;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        ADDR_STATUS: begin
          avs_readdata <= status_word;
        end
        ADDR_OFFSETS: begin
          avs_readdata <= {4'h0, full_ofs_r, 4'h0, empty_ofs_r};
        end
        default: begin
          avs_readdata <= '0; // unmapped reads return zero
        end
      endcase
    end
  end

endmodule : dcf_fifo
`default_nettype wire

// File: logic/dcf_pin_sync.sv
// two-flop synchroniser bank with edge detection per bit
// assumes every pin bit is asynchronous to clk and slower than clk/2
`timescale 1ns/1ps
`default_nettype none
module dcf_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // per bit: first stage feeds only the second; edges come from later stages
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
        prev_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pin_in[i];
        sync_r[i] <= meta_r[i];
        prev_r[i] <= sync_r[i];
      end
    end
    assign level_out[i] = sync_r[i];
    assign rise_out[i] = sync_r[i] & ~prev_r[i];
    assign fall_out[i] = ~sync_r[i] & prev_r[i];
  end

endmodule : dcf_pin_sync
`default_nettype wire

// File: logic/dcf_pkg.sv
// constants shared by the dual clock fifo core, its checker, the pin partner and the bench
// assumes a single fast system clock that oversamples both pin clocks
package dcf_pkg;

  // data path and offset field widths
  localparam int unsigned DATA_W = 18;
  localparam int unsigned OFS_W = 12;
  localparam int unsigned CNT_W = 13;

  // depth limits served by the logic
  localparam int unsigned DEPTH_MIN = 256;
  localparam int unsigned DEPTH_MAX = 4096;
  localparam int unsigned DEPTH_DEF = 256;

  // offset defaults per depth class
  localparam logic [11:0] OFS_DEF_256 = 12'h01f;
  localparam logic [11:0] OFS_DEF_512 = 12'h03f;
  localparam logic [11:0] OFS_DEF_BIG = 12'h07f;

  // read clock transitions before the first word falls through
  localparam logic [1:0] FT_TRANSITIONS = 2'h3;

  // pin pattern (first_load, read_expand_in, write_expand_in) picking fall-through
  localparam logic [2:0] FT_MODE_PINS = 3'h1;

  // avalon register byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_OFFSETS = 4'h4;

  // status word field positions
  localparam int unsigned ST_COUNT_LSB = 0;
  localparam int unsigned ST_MODE_BIT = 16;
  localparam int unsigned ST_EMPTY_BIT = 17;
  localparam int unsigned ST_AE_BIT = 18;
  localparam int unsigned ST_HF_BIT = 19;
  localparam int unsigned ST_AF_BIT = 20;
  localparam int unsigned ST_FULL_BIT = 21;
  localparam int unsigned ST_RESET_BIT = 22;

  // offsets word field positions
  localparam int unsigned OF_EMPTY_LSB = 0;
  localparam int unsigned OF_FULL_LSB = 16;

  // offset default for a given depth
  function automatic logic [11:0] dcf_ofs_default(input int unsigned depth);
    logic [11:0] v;
    v = OFS_DEF_BIG;
    if (depth == 256) begin
      v = OFS_DEF_256;
    end else if (depth == 512) begin
      v = OFS_DEF_512;
    end
    return v;
  endfunction : dcf_ofs_default

endpackage : dcf_pkg

// File: test/dcf_fifo_monitor.sv
// checker on dcf_fifo ports: flag pairs, flag causes, output hold
// assumes pin clocks far below clk; bound into every dcf_fifo
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_monitor
  import dcf_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic device_reset_pin_n,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic full_flag_n,
  input wire logic input_ready_n,
  input wire logic almost_full_flag_n,
  input wire logic half_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic empty_flag_n,
  input wire logic output_ready_n,
  input wire logic fall_through_mode
);
  logic [7:0] wr_age_r;
  logic [7:0] rd_age_r;
  logic [7:0] rs_age_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles since each pin was low; saturates so old history stays inert
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_age_r <= 8'hff;
      rd_age_r <= 8'hff;
      rs_age_r <= 8'h00;
    end else begin
      wr_age_r <= !wr_en_n ? 8'h00 : wr_age_r + {7'h00, wr_age_r != 8'hff};
      rd_age_r <= !rd_en_n ? 8'h00 : rd_age_r + {7'h00, rd_age_r != 8'hff};
      rs_age_r <= !device_reset_pin_n ? 8'h00 : rs_age_r + {7'h00, rs_age_r != 8'hff};
    end
  end

  full_pair_a: assert property (full_flag_n != input_ready_n)
    else $error("full and input ready agree");
  ready_pair_a: assert property (empty_flag_n != output_ready_n)
    else $error("empty and output ready agree");
  full_chain_a: assert property (!full_flag_n
    |-> !almost_full_flag_n && !half_full_flag_n)
    else $error("full without partial flags");
  empty_ae_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  std_hold_a: assert property ((!fall_through_mode && rd_en_n && device_reset_pin_n)[*8]
    |=> $stable(data_out))
    else $error("output moved without a read");
  full_cause_a: assert property ($fell(full_flag_n) |-> wr_age_r < 8'h14)
    else $error("full without a write");
  empty_cause_a: assert property ($fell(empty_flag_n)
    |-> rd_age_r < 8'h14 || rs_age_r < 8'h14)
    else $error("empty without a read");
  first_word_a: assert property ($rose(empty_flag_n) && !fall_through_mode
    |-> wr_age_r < 8'h14)
    else $error("word flag without a write");
  mode_latch_a: assert property ($changed(fall_through_mode) |-> rs_age_r < 8'h05)
    else $error("mode changed outside reset");

  cover property (!full_flag_n && !fall_through_mode);
  cover property (!full_flag_n && fall_through_mode);
  cover property ($rose(empty_flag_n) && fall_through_mode);
endmodule : dcf_fifo_monitor

bind dcf_fifo dcf_fifo_monitor #(.DEPTH(DEPTH)) u_dcf_mon (
  .clk(clk), .rst_n(rst_n), .device_reset_pin_n(device_reset_pin_n),
  .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .data_out(data_out),
  .full_flag_n(full_flag_n), .input_ready_n(input_ready_n),
  .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n), .empty_flag_n(empty_flag_n),
  .output_ready_n(output_ready_n), .fall_through_mode(fall_through_mode)
);
`default_nettype wire

// File: test/dcf_pin_partner.sv
// producer and consumer logic on the fifo write and read pins
// assumes go is held by the bench until busy is seen high
`timescale 1ns/1ps
`default_nettype none
module dcf_pin_partner
  import dcf_pkg::*;
(
  input wire logic clk,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic [DATA_W-1:0] wr_word,
  output logic wr_clk_pin,
  output logic rd_clk_pin,
  output logic wr_en_n,
  output logic rd_en_n,
  output logic [DATA_W-1:0] data_in,
  output logic wr_busy,
  output logic rd_busy
);
  logic wr_hi_r;
  logic rd_hi_r;

  // free running pin clocks; odd offsets keep edges off clk edges
  initial begin
    wr_clk_pin = 1'b0;
    #1.1;
    forever #62.5 wr_clk_pin = ~wr_clk_pin;
  end
  initial begin
    rd_clk_pin = 1'b0;
    #20.3;
    forever #62.5 rd_clk_pin = ~rd_clk_pin;
  end
  initial begin
    {wr_en_n, rd_en_n, wr_busy, rd_busy, wr_hi_r, rd_hi_r} = 6'h30;
    data_in = 18'h0_0000;
  end

  // one write per pin rise: enable set while low, dropped after the fall
  always @(posedge clk) begin
    if (!wr_busy && wr_go && !wr_clk_pin) begin
      wr_en_n <= 1'b0;
      data_in <= wr_word;
      wr_busy <= 1'b1;
      wr_hi_r <= 1'b0;
    end else if (wr_busy && wr_clk_pin) begin
      wr_hi_r <= 1'b1;
    end else if (wr_busy && wr_hi_r) begin
      wr_en_n <= 1'b1;
      data_in <= ~data_in; // stale data flips so it never looks valid
      wr_busy <= 1'b0;
    end
  end

  // one read per pin rise, same framing as the write side
  always @(posedge clk) begin
    if (!rd_busy && rd_go && !rd_clk_pin) begin
      rd_en_n <= 1'b0;
      rd_busy <= 1'b1;
      rd_hi_r <= 1'b0;
    end else if (rd_busy && rd_clk_pin) begin
      rd_hi_r <= 1'b1;
    end else if (rd_busy && rd_hi_r) begin
      rd_en_n <= 1'b1;
      rd_busy <= 1'b0;
    end
  end
endmodule : dcf_pin_partner
`default_nettype wire

// File: test/tb.sv
// bench: register table, then fill, overflow and drain in both modes
// assumes dcf_fifo at depth 256 with the pin partner on both ports
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcf_pkg::*;
  localparam int D = 256;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [31:0] wd;
    logic [31:0] ex;
  } dcf_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_n = 1'b0;
  logic ld_n = 1'b1;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [2:0] cfg = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] avs_rd;
  logic [DATA_W-1:0] word = 18'h0_0000;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] dout;
  logic [6:0] flg;
  logic wclk, rclk, wen_n, ren_n, wbusy, rbusy, mode, wait_r;
  int bad_count = 0;
  int tests_run = 0;
  int n = 31;
  int m = 31;
  int k_ft = 0;
  // status, defaults, unmapped place, reserved offset bits
  dcf_row_s rows [7] = '{
    '{1'b0, 4'h0, 32'h0000_0000, 32'h0006_0000},
    '{1'b0, 4'h4, 32'h0000_0000, 32'h001f_001f},
    '{1'b0, 4'h8, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, 4'hc, 32'hffff_ffff, 32'h0000_0000},
    '{1'b0, 4'h4, 32'h0000_0000, 32'h001f_001f},
    '{1'b1, 4'h4, 32'hf003_f002, 32'h0000_0000},
    '{1'b0, 4'h4, 32'h0000_0000, 32'h0003_0002}};

  always #2.5 clk = ~clk;

  dcf_fifo #(.DEPTH(D)) dut (
    .clk(clk), .rst_n(rst_n), .device_reset_pin_n(dev_n), .first_load_pin(cfg[2]),
    .read_expand_in(cfg[1]), .write_expand_in(cfg[0]), .offset_load_n(ld_n),
    .wr_clk_pin(wclk), .wr_en_n(wen_n), .data_in(din), .rd_clk_pin(rclk),
    .rd_en_n(ren_n), .data_out(dout), .full_flag_n(flg[6]), .input_ready_n(flg[5]),
    .almost_full_flag_n(flg[4]), .half_full_flag_n(flg[3]),
    .almost_empty_flag_n(flg[2]), .empty_flag_n(flg[1]), .output_ready_n(flg[0]),
    .fall_through_mode(mode), .avs_address(addr), .avs_read(rd_i), .avs_write(wr_i),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(avs_rd),
    .avs_waitrequest(wait_r));
  dcf_pin_partner pp (.clk(clk), .wr_go(wr_go), .rd_go(rd_go), .wr_word(word),
    .wr_clk_pin(wclk), .rd_clk_pin(rclk), .wr_en_n(wen_n), .rd_en_n(ren_n),
    .data_in(din), .wr_busy(wbusy), .rd_busy(rbusy));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // expected flags from the word count; fall-through adds the output slot
  task automatic check_flags(input int c);
    int k;
    logic [6:0] e;
    k = k_ft;
    e = {c != D + k, c == D + k, c + m < D + k, c < D / 2 + 1 + k, c >= n + 1 + k,
      c > 0, c == 0};
    check({25'h000_0000, flg}, {25'h000_0000, e});
  endtask : check_flags

  // bounded wait on partner busy (0, 1) or waitrequest (2)
  task automatic wait_lvl(input int s, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      if ((s == 0 ? wbusy : s == 1 ? rbusy : wait_r) === v) break;
      @(posedge clk);
    end
    if (i == 300) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_lvl

  task automatic bus(input dcf_row_s r);
    @(posedge clk);
    wr_i <= r.wr;
    rd_i <= !r.wr;
    addr <= r.a;
    wdata <= r.wd;
    @(posedge clk);
    wait_lvl(2, 1'b0);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    if (!r.wr) check(avs_rd, r.ex);
  endtask : bus

  task automatic push(input logic [DATA_W-1:0] d);
    wr_go <= 1'b1;
    word <= d;
    wait_lvl(0, 1'b1);
    wr_go <= 1'b0;
    wait_lvl(0, 1'b0);
  endtask : push

  task automatic pop;
    rd_go <= 1'b1;
    wait_lvl(1, 1'b1);
    rd_go <= 1'b0;
    wait_lvl(1, 1'b0);
  endtask : pop

  function automatic logic [31:0] w(input int i);
    return {14'h0000, 18'h2_aa00 ^ DATA_W'(i)};
  endfunction : w

  // fill one past capacity, then drain one past empty
  task automatic fill_drain(input int cap);
    for (int i = 0; i <= cap; i++) begin
      push(DATA_W'(w(i)));
      if (i == 0) repeat (60) @(posedge clk);
      if (i == 0) check({14'h0000, dout}, cap > D ? w(0) : 32'h0000_0000);
      check_flags(i < cap ? i + 1 : cap);
    end
    for (int i = 0; i <= cap; i++) begin
      if (cap > D && i < cap) check({14'h0000, dout}, w(i));
      pop();
      if (cap == D) check({14'h0000, dout}, w(i < D ? i : D - 1));
      check_flags(i < cap ? cap - 1 - i : 0);
    end
  endtask : fill_drain

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    dev_n <= 1'b1;
    repeat (10) @(posedge clk);
    check_flags(0);
    foreach (rows[i]) bus(rows[i]);
    $display("register table done");
    ld_n <= 1'b0;
    push(18'h3_f00a);
    push(18'h0_0014);
    ld_n <= 1'b1;
    bus(dcf_row_s'{1'b0, 4'h4, 32'h0000_0000, 32'h0014_000a});
    n = 10;
    m = 20;
    fill_drain(D);
    $display("standard mode done");
    dev_n <= 1'b0;
    cfg <= 3'h1;
    repeat (10) @(posedge clk);
    dev_n <= 1'b1;
    repeat (10) @(posedge clk);
    check({31'h0000_0000, mode}, 32'h0000_0001);
    bus(dcf_row_s'{1'b1, 4'h4, 32'h000a_0005, 32'h0000_0000});
    n = 5;
    m = 10;
    k_ft = 1;
    fill_drain(D + 1);
    $display("fall-through mode done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
